// ==== hw/lin_wake_fault_control_map.svh ====
// Offsets-free constant map: mode codes, clock rate, timing counts and buffer defaults
`ifndef LIN_WAKE_FAULT_CONTROL_MAP_SVH
`define LIN_WAKE_FAULT_CONTROL_MAP_SVH

// Transceiver mode field encodings (wake-capable is fixed at 01)
`define TRX_MODE_OFF 2'h0
`define TRX_MODE_WAKE 2'h1
`define TRX_MODE_NORMAL 2'h2
`define TRX_MODE_RXONLY 2'h3
// Chip mode encodings
`define CHIP_NORMAL 3'h0
`define CHIP_STOP 3'h1
`define CHIP_SLEEP 3'h2
`define CHIP_RESTART 3'h3
`define CHIP_FAILSAFE 3'h4
// Clock rate in kHz
`define CLK_KHZ 25000
// Wake filter: least 30 us, longest 150 us; filter uses the least, rounded up
`define WAKE_FILTER_MIN_US 30
`define WAKE_FILTER_MAX_US 150
`define WAKE_FILTER_CYC ((`WAKE_FILTER_MIN_US * `CLK_KHZ + 999) / 1000)
// Transmit and bus dominant time-outs, in ms
`define TX_TIMEOUT_MS 20
`define BUS_TIMEOUT_MS 20
`define TX_TIMEOUT_CYC (`TX_TIMEOUT_MS * `CLK_KHZ)
`define BUS_TIMEOUT_CYC (`BUS_TIMEOUT_MS * `CLK_KHZ)
// Buffer defaults
`define FIFO_DEPTH 32
`define FIFO_WIDTH 8

`endif

// ==== hw/lin_wake_pkg.sv ====
// Package with the types shared by the transceiver control block
package lin_wake_pkg;
  // Two-bit transceiver mode field
  typedef logic [1:0] trx_mode_t;
  // Chip mode code
  typedef logic [2:0] chip_mode_t;
  // Wake report state
  typedef enum logic [1:0] {WK_ARMED, WK_FIRED, WK_DISARMED} wake_state_t;
  // Serial configuration written by the host
  typedef struct packed {
    trx_mode_t mode;
    logic low_slope;
    logic slope_bypass;
    logic watchdog_on_bus_wake;
  } cfg_t;
  // Status seen by the host
  typedef struct packed {
    logic wake_status;
    logic channel_failure;
    logic driver_en;
    logic receiver_en;
  } status_t;
endpackage

// ==== hw/dominant_timer.sv ====
// Counts consecutive cycles a level is asserted and flags when it reaches a limit
`timescale 1ns/1ps
module dominant_timer #(
  parameter int unsigned LIMIT = 30,
  parameter int unsigned W = 20
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic level_i,
  output logic expired_o
);
  // Saturating counter of dominant cycles
  logic [W-1:0] cnt_q;

  // Count while asserted, clear otherwise
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (!level_i) begin
      cnt_q <= '0;
    end else if (cnt_q < W'(LIMIT)) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // Expired once the count reaches the limit
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= level_i && (cnt_q >= W'(LIMIT - 1));
    end
  end
endmodule

// ==== hw/data_fifo.sv ====
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module data_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  // Storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Write side
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== hw/lin_wake_fault_control.sv ====
// Transceiver control: wake detection, time-outs, under-voltage and slope selection
// Notes on behaviour
// - Wake-capable mode selectable in stop/sleep/restart/normal
// - Fail-safe chip mode forces wake-capable mode
// - Wake needs dominant longer than filter time
// - Receive output low after wake until mode change
// - Mode field keeps reading 01 after wake
// - Leaving and reselecting wake-capable mode rearms detection
// - Entering stop, sleep or fail-safe rearms
// - Stop/normal wake: interrupt low, status set, mode kept
// - Bus wake in stop mode enables disabled watchdog if configured
// - Sleep wake: restart mode, regulator ramps, receive low
// - No interrupt when leaving sleep by wake
// - Fail-safe wake goes restart; restart stays restart
// - Transmit time-out disables driver, sets failure flag
// - Driver re-enabled once transmit input recessive
// - Bus dominant time-out sets failure flag
// - Under-voltage disables driver and receiver temporarily
// - Normal slope default; low slope on select release
// - Slope bit changes accepted only in normal mode
// - Slope bypass in normal mode, on select release
// - Transmit time-out is 20 ms
// - Bus dominant time-out is 20 ms
// - Off mode after reset ignores wakes
`timescale 1ns/1ps
`include "lin_wake_fault_control_map.svh"
module lin_wake_fault_control #(
  parameter int unsigned TX_TIMEOUT = `TX_TIMEOUT_CYC,
  parameter int unsigned BUS_TIMEOUT = `BUS_TIMEOUT_CYC,
  parameter int unsigned FIFO_W = `FIFO_WIDTH,
  parameter int unsigned FIFO_D = `FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire lin_wake_pkg::cfg_t cfg_i,
  input wire logic cfg_write_i,
  input wire logic serial_select_n_i,
  input wire lin_wake_pkg::chip_mode_t chip_mode_i,
  input wire logic watchdog_enabled_i,
  input wire logic wake_status_clear_i,
  input wire logic fail_clear_i,
  input wire logic bus_transmit_in_i,
  input wire logic bus_rx_i,
  input wire logic bus_supply_uv_i,
  input wire logic [FIFO_W-1:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [FIFO_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output lin_wake_pkg::trx_mode_t channel_a_mode_field_o,
  output lin_wake_pkg::status_t status_o,
  output logic receive_out_o,
  output logic bus_drive_o,
  output logic bus_drive_oe_o,
  output logic int_n_o,
  output logic chip_to_restart_o,
  output logic regulator_ramp_o,
  output logic watchdog_enable_o,
  output logic low_slope_select_o,
  output logic slope_bypass_o
);
  import lin_wake_pkg::*;

  // Pin synchronisers and the previous synced select level
  logic [1:0] txd_sync_q, bus_sync_q, uv_sync_q, cs_sync_q;
  logic cs_prev_q;
  // Configuration state
  trx_mode_t mode_q;
  logic low_slope_pend_q, bypass_pend_q, wd_on_wake_q;
  chip_mode_t chip_prev_q;
  // Wake machine, flags and transmit block
  wake_state_t wake_q;
  logic wake_status_q, fail_q, tx_blocked_q;
  // Synced levels, filter results and decoded events
  logic wake_seen, tx_dom, bus_dom, cs_rise, chip_entry_rearm;
  logic tx_expired, bus_expired, wake_expired;
  // Buffer side signals
  logic fifo_out_valid, fifo_in_ready;
  logic [FIFO_W-1:0] fifo_out_data;

  // True for chip modes in which software may pick wake-capable mode
  function automatic logic wake_mode_allowed(input chip_mode_t m);
    return (m == `CHIP_STOP) || (m == `CHIP_SLEEP) || (m == `CHIP_RESTART)
      || (m == `CHIP_NORMAL);
  endfunction
  // True for chip modes whose entry rearms wake detection
  function automatic logic rearm_mode(input chip_mode_t m);
    return (m == `CHIP_STOP) || (m == `CHIP_SLEEP) || (m == `CHIP_FAILSAFE);
  endfunction

  // Two flip-flops on every pin input
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      txd_sync_q <= 2'h3;
      bus_sync_q <= 2'h3;
      uv_sync_q <= 2'h0;
      cs_sync_q <= 2'h3;
      cs_prev_q <= 1'b1;
    end else begin
      txd_sync_q <= {txd_sync_q[0], bus_transmit_in_i};
      bus_sync_q <= {bus_sync_q[0], bus_rx_i};
      uv_sync_q <= {uv_sync_q[0], bus_supply_uv_i};
      cs_sync_q <= {cs_sync_q[0], serial_select_n_i};
      cs_prev_q <= cs_sync_q[1];
    end
  end
  assign tx_dom = !txd_sync_q[1];
  assign bus_dom = !bus_sync_q[1];
  assign cs_rise = cs_sync_q[1] && !cs_prev_q;
  assign chip_entry_rearm = rearm_mode(chip_mode_i) && (chip_mode_i != chip_prev_q);
  // Dominant filters for wake, transmit and bus time-outs
  dominant_timer #(.LIMIT(`WAKE_FILTER_CYC + 1), .W(12)) u_wake_filt (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .level_i(bus_dom && !uv_sync_q[1]),
    .expired_o(wake_expired)
  );
  dominant_timer #(.LIMIT(TX_TIMEOUT + 1), .W(24)) u_tx_to (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .level_i(tx_dom),
    .expired_o(tx_expired)
  );
  dominant_timer #(.LIMIT(BUS_TIMEOUT + 1), .W(24)) u_bus_to (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .level_i(bus_dom),
    .expired_o(bus_expired)
  );

  assign wake_seen = wake_expired && (mode_q == `TRX_MODE_WAKE) && (wake_q == WK_ARMED);
  // Chip mode history
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      chip_prev_q <= `CHIP_NORMAL;
    end else begin
      chip_prev_q <= chip_mode_i;
    end
  end

  // Transceiver mode field; off after reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_q <= `TRX_MODE_OFF;
    end else if (chip_mode_i == `CHIP_FAILSAFE) begin
      mode_q <= `TRX_MODE_WAKE;
    end else if (cfg_write_i) begin
      if (cfg_i.mode != `TRX_MODE_WAKE || wake_mode_allowed(chip_mode_i)) begin
        mode_q <= cfg_i.mode;
      end
    end
  end

  // Slope settings staged on write, applied on select release, normal mode only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      low_slope_pend_q <= 1'b0;
      bypass_pend_q <= 1'b0;
      wd_on_wake_q <= 1'b0;
    end else if (cfg_write_i) begin
      wd_on_wake_q <= cfg_i.watchdog_on_bus_wake;
      if (chip_mode_i == `CHIP_NORMAL) begin
        low_slope_pend_q <= cfg_i.low_slope;
        bypass_pend_q <= cfg_i.slope_bypass;
      end
    end
  end

  // Effective slope outputs
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      low_slope_select_o <= 1'b0;
      slope_bypass_o <= 1'b0;
    end else if (cs_rise && chip_mode_i == `CHIP_NORMAL) begin
      low_slope_select_o <= low_slope_pend_q;
      slope_bypass_o <= bypass_pend_q;
    end
  end

  // Wake machine: armed, fired, disarmed
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wake_q <= WK_ARMED;
    end else begin
      case (wake_q)
        WK_ARMED: begin
          if (wake_seen) begin
            wake_q <= WK_FIRED;
          end
        end
        WK_FIRED: begin
          if (mode_q != `TRX_MODE_WAKE) begin
            wake_q <= WK_DISARMED;
          end else if (chip_entry_rearm) begin
            wake_q <= WK_ARMED;
          end
        end
        WK_DISARMED: begin
          if (mode_q == `TRX_MODE_WAKE || chip_entry_rearm) begin
            wake_q <= WK_ARMED;
          end
        end
        default: begin
          wake_q <= WK_ARMED;
        end
      endcase
    end
  end

  // Wake status; a new wake wins over a clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wake_status_q <= 1'b0;
    end else if (wake_seen) begin
      wake_status_q <= 1'b1;
    end else if (wake_status_clear_i) begin
      wake_status_q <= 1'b0;
    end
  end

  // Interrupt: low pulse for wakes in stop or normal only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= !(wake_seen && (chip_mode_i == `CHIP_STOP
        || chip_mode_i == `CHIP_NORMAL));
    end
  end

  // Restart request for wakes in sleep, fail-safe or restart; regulator ramp for wakes in sleep or fail-safe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      chip_to_restart_o <= 1'b0;
      regulator_ramp_o <= 1'b0;
    end else begin
      chip_to_restart_o <= wake_seen && (chip_mode_i == `CHIP_SLEEP
        || chip_mode_i == `CHIP_FAILSAFE || chip_mode_i == `CHIP_RESTART);
      regulator_ramp_o <= wake_seen && (chip_mode_i == `CHIP_SLEEP
        || chip_mode_i == `CHIP_FAILSAFE);
    end
  end

  // Watchdog auto-enable on bus wake in stop mode
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      watchdog_enable_o <= 1'b0;
    end else begin
      watchdog_enable_o <= wake_seen && wd_on_wake_q && !watchdog_enabled_i
        && chip_mode_i == `CHIP_STOP;
    end
  end

  // Transmit blocking after time-out until recessive
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_blocked_q <= 1'b0;
    end else if (tx_expired) begin
      tx_blocked_q <= 1'b1;
    end else if (!tx_dom) begin
      tx_blocked_q <= 1'b0;
    end
  end

  // Failure flag; set wins over clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fail_q <= 1'b0;
    end else if (tx_expired || bus_expired) begin
      fail_q <= 1'b1;
    end else if (fail_clear_i) begin
      fail_q <= 1'b0;
    end
  end

  // Pin and status outputs
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      receive_out_o <= 1'b1;
      bus_drive_o <= 1'b1;
      bus_drive_oe_o <= 1'b0;
      status_o <= '0;
      channel_a_mode_field_o <= `TRX_MODE_OFF;
    end else begin
      channel_a_mode_field_o <= mode_q;
      if (wake_q == WK_FIRED && mode_q == `TRX_MODE_WAKE) begin
        receive_out_o <= 1'b0;
      end else if (uv_sync_q[1] || mode_q == `TRX_MODE_OFF || mode_q == `TRX_MODE_WAKE) begin
        receive_out_o <= 1'b1;
      end else begin
        receive_out_o <= bus_sync_q[1];
      end
      bus_drive_o <= 1'b0;
      bus_drive_oe_o <= (mode_q == `TRX_MODE_NORMAL) && tx_dom && !tx_blocked_q
        && !tx_expired && !uv_sync_q[1];
      status_o.wake_status <= wake_status_q;
      status_o.channel_failure <= fail_q;
      status_o.driver_en <= (mode_q == `TRX_MODE_NORMAL) && !tx_blocked_q && !uv_sync_q[1];
      status_o.receiver_en <= (mode_q != `TRX_MODE_OFF) && !uv_sync_q[1];
    end
  end
  // Receive data buffer toward the host; only words offered while ready shows high go in
  data_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_data_i(rx_data_i),
    .in_valid_i(rx_valid_i && rx_ready_o),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!rx_valid_o || rx_ready_i)
  );

  // Registered buffer outputs; the slot refills when empty or being taken, otherwise holds until ready
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
      rx_ready_o <= 1'b0;
    end else begin
      // Ready drops for a cycle after each taken word so it never claims room that is gone
      rx_ready_o <= fifo_in_ready && !(rx_valid_i && rx_ready_o);
      if (!rx_valid_o || rx_ready_i) begin
        rx_valid_o <= fifo_out_valid;
        rx_data_o <= fifo_out_valid ? fifo_out_data : rx_data_o;
      end
    end
  end
  // No interrupt, restart request or regulator ramp outside wake-capable mode
  chk_wake_mode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_q != `TRX_MODE_WAKE |=> int_n_o && !chip_to_restart_o && !regulator_ramp_o)
    else $error("wake reported outside wake-capable mode");
  // Receive stays low while fired in wake mode
  chk_rx_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wake_q == WK_FIRED && mode_q == `TRX_MODE_WAKE) |=> !receive_out_o)
    else $error("receive not low after wake");
  // No interrupt on sleep wake
  chk_sleep_int: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wake_seen && chip_mode_i == `CHIP_SLEEP) |=> int_n_o && chip_to_restart_o)
    else $error("sleep wake handled wrongly");
  // Stop wake gives interrupt and status
  chk_stop_int: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wake_seen && chip_mode_i == `CHIP_STOP) |=> !int_n_o && wake_status_q)
    else $error("stop wake not reported");
  // Driver off while blocked
  chk_tx_block: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_expired |=> !bus_drive_oe_o && fail_q)
    else $error("driver active after time-out");
  // Driver released after recessive
  chk_tx_free: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (tx_blocked_q && !tx_dom && !tx_expired) |=> !tx_blocked_q)
    else $error("driver not released");
  // Bus time-out sets failure
  chk_bus_fail: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_expired |=> fail_q)
    else $error("bus clamp not flagged");
  // Under-voltage keeps driver off
  chk_uv_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    uv_sync_q[1] |=> !bus_drive_oe_o)
    else $error("driver on under-voltage");
  // Fail-safe forces wake mode
  chk_failsafe: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    chip_mode_i == `CHIP_FAILSAFE |=> mode_q == `TRX_MODE_WAKE)
    else $error("fail-safe did not force wake mode");
endmodule

// ==== test/lin_bus_node.sv ====
// Behavioural model of the single-wire bus with its pull-up and one remote node
`timescale 1ns/1ps
module lin_bus_node (
  input wire logic drive_i,
  input wire logic drive_oe_i,
  input wire logic remote_dom_i,
  output logic bus_level_o
);
  // Wired-AND: any dominant driver pulls the line low, else the pull-up wins
  assign bus_level_o = !((drive_oe_i && !drive_i) || remote_dom_i);
endmodule

// ==== test/lin_wake_fault_control_tb.sv ====
// Self-checking testbench for the transceiver wake and fault control block
`timescale 1ns/1ps
`include "lin_wake_fault_control_map.svh"
module lin_wake_fault_control_tb;
  import lin_wake_pkg::*;
  localparam int unsigned TXT = 50; // Shortened transmit time-out
  localparam int unsigned BT = 50; // Shortened bus time-out
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  cfg_t cfg_i = '0;
  logic cfg_write_i = 1'b0, sel_n = 1'b1, wd_on = 1'b0, wk_clr = 1'b0, f_clr = 1'b0;
  logic tx_in = 1'b1, uv = 1'b0, remote_dom = 1'b0, bus_rx, fin_valid = 1'b0, fout_ready = 1'b0;
  chip_mode_t chip = `CHIP_NORMAL;
  logic [7:0] fin_data = 8'h00, fout_data;
  logic fin_ready, fout_valid, rx_o, drv, drv_oe, int_n, to_rst, ramp, wd_pulse, ls, bp;
  trx_mode_t field;
  status_t st;
  int err_total = 0, n_tests = 0;
  int n_int = 0, n_rst = 0, n_ramp = 0, n_wd = 0; // Pulse tallies since last clear
  logic [7:0] q[$];
  // Clock: 25 MHz
  always #20 clk_i = ~clk_i;
  lin_wake_fault_control #(.TX_TIMEOUT(TXT), .BUS_TIMEOUT(BT)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg_i), .cfg_write_i(cfg_write_i),
    .serial_select_n_i(sel_n), .chip_mode_i(chip), .watchdog_enabled_i(wd_on),
    .wake_status_clear_i(wk_clr), .fail_clear_i(f_clr), .bus_transmit_in_i(tx_in),
    .bus_rx_i(bus_rx), .bus_supply_uv_i(uv), .rx_data_i(fin_data), .rx_valid_i(fin_valid),
    .rx_ready_o(fin_ready), .rx_data_o(fout_data), .rx_valid_o(fout_valid),
    .rx_ready_i(fout_ready), .channel_a_mode_field_o(field), .status_o(st),
    .receive_out_o(rx_o), .bus_drive_o(drv), .bus_drive_oe_o(drv_oe), .int_n_o(int_n),
    .chip_to_restart_o(to_rst), .regulator_ramp_o(ramp), .watchdog_enable_o(wd_pulse),
    .low_slope_select_o(ls), .slope_bypass_o(bp));
  // Far-side bus with the remote node
  lin_bus_node u_bus (.drive_i(drv), .drive_oe_i(drv_oe), .remote_dom_i(remote_dom),
    .bus_level_o(bus_rx));
  // Tally the one-cycle event pulses
  always @(posedge clk_i) begin
    if (int_n === 1'b0) n_int++;
    if (to_rst === 1'b1) n_rst++;
    if (ramp === 1'b1) n_ramp++;
    if (wd_pulse === 1'b1) n_wd++;
  end
  // Wait whole cycles, landing on a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Compare one value and count it
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One serial configuration write; watchdog-on-wake bit always set
  task automatic wcfg(input trx_mode_t m, input logic l, input logic b);
    cfg_i = '{mode: m, low_slope: l, slope_bypass: b, watchdog_on_bus_wake: 1'b1};
    cfg_write_i = 1'b1;
    cyc(1);
    cfg_write_i = 1'b0;
    cyc(3);
  endtask
  // Clear status flags and pulse tallies
  task automatic clr();
    wk_clr = 1'b1;
    f_clr = 1'b1;
    cyc(1);
    wk_clr = 1'b0;
    f_clr = 1'b0;
    n_int = 0; n_rst = 0; n_ramp = 0; n_wd = 0;
  endtask
  // Remote node holds the bus dominant for n cycles, then releases it
  task automatic wake(input int n);
    remote_dom = 1'b1;
    cyc(n);
    remote_dom = 1'b0;
    cyc(5);
  endtask
  // Expected wake outcome: interrupt, restart, ramp pulse counts and receive level
  task automatic wk_exp(input logic [7:0] ei, er, ep, input logic rx);
    check("int_pulses", 8'(n_int), ei);
    check("restart_pulses", 8'(n_rst), er);
    check("ramp_pulses", 8'(n_ramp), ep);
    check("receive_out", rx_o, rx);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  // Verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog: the tests need about 7600 cycles
  initial begin
    #(40 * 40000);
    err_total++;
    end_of_test();
  end
  // Main sequence
  initial begin
    cyc(10);
    reset_n_i = 1'b1;
    cyc(1);
    check("field_rst", field, `TRX_MODE_OFF);
    check("int_rst", int_n, 1'b1);
    check("ls_rst", ls, 1'b0);
    check("bp_rst", bp, 1'b0);
    wake(800);
    check("off_wake", st.wake_status, 1'b0);
    check("off_fail", st.channel_failure, 1'b1);
    done("off");
    clr();
    wcfg(`TRX_MODE_WAKE, 1'b0, 1'b0);
    check("field_wk", field, `TRX_MODE_WAKE);
    wake(700);
    check("short_wake", st.wake_status, 1'b0);
    wake(800);
    wk_exp(8'd1, 8'd0, 8'd0, 1'b0);
    check("wk_stat", st.wake_status, 1'b1);
    check("field_after", field, `TRX_MODE_WAKE);
    check("wd_norm", 8'(n_wd), 8'd0);
    done("wake_normal");
    clr();
    wake(800);
    wk_exp(8'd0, 8'd0, 8'd0, 1'b0);
    wcfg(`TRX_MODE_NORMAL, 1'b0, 1'b0);
    check("rx_left", rx_o, 1'b1);
    wcfg(`TRX_MODE_WAKE, 1'b0, 1'b0);
    clr();
    wake(800);
    wk_exp(8'd1, 8'd0, 8'd0, 1'b0);
    done("rearm");
    wd_on = 1'b0;
    chip = `CHIP_STOP;
    cyc(3);
    clr();
    wake(800);
    wk_exp(8'd1, 8'd0, 8'd0, 1'b0);
    check("wd_stop", 8'(n_wd), 8'd1);
    chip = `CHIP_NORMAL;
    wd_on = 1'b1;
    done("stop");
    chip = `CHIP_SLEEP;
    cyc(3);
    clr();
    wake(800);
    wk_exp(8'd0, 8'd1, 8'd1, 1'b0);
    check("sleep_stat", st.wake_status, 1'b1);
    done("sleep");
    chip = `CHIP_RESTART;
    wcfg(`TRX_MODE_OFF, 1'b0, 1'b0);
    chip = `CHIP_FAILSAFE;
    cyc(4);
    check("fs_field", field, `TRX_MODE_WAKE);
    clr();
    wake(800);
    wk_exp(8'd0, 8'd1, 8'd1, 1'b0);
    chip = `CHIP_RESTART;
    wcfg(`TRX_MODE_NORMAL, 1'b0, 1'b0);
    wcfg(`TRX_MODE_WAKE, 1'b0, 1'b0);
    clr();
    wake(800);
    wk_exp(8'd0, 8'd1, 8'd0, 1'b0);
    done("failsafe_restart");
    chip = `CHIP_NORMAL;
    wcfg(`TRX_MODE_NORMAL, 1'b0, 1'b0);
    clr();
    tx_in = 1'b0;
    cyc(TXT - 10);
    check("oe_before", drv_oe, 1'b1);
    cyc(20);
    check("oe_after", drv_oe, 1'b0);
    check("tx_fail", st.channel_failure, 1'b1);
    check("tx_drven", st.driver_en, 1'b0);
    check("tx_field", field, `TRX_MODE_NORMAL);
    tx_in = 1'b1;
    cyc(5);
    tx_in = 1'b0;
    cyc(5);
    check("oe_back", drv_oe, 1'b1);
    tx_in = 1'b1;
    done("tx_timeout");
    wcfg(`TRX_MODE_RXONLY, 1'b0, 1'b0);
    clr();
    wake(BT - 10);
    check("clamp_short", st.channel_failure, 1'b0);
    wake(BT + 20);
    check("clamp_long", st.channel_failure, 1'b1);
    check("clamp_field", field, `TRX_MODE_RXONLY);
    done("clamp");
    wcfg(`TRX_MODE_NORMAL, 1'b0, 1'b0);
    uv = 1'b1;
    tx_in = 1'b0;
    cyc(8);
    check("uv_oe", drv_oe, 1'b0);
    check("uv_rxen", st.receiver_en, 1'b0);
    check("uv_drven", st.driver_en, 1'b0);
    uv = 1'b0;
    cyc(5);
    check("uv_oe_back", drv_oe, 1'b1);
    check("uv_field", field, `TRX_MODE_NORMAL);
    tx_in = 1'b1;
    done("undervoltage");
    sel_n = 1'b0;
    wcfg(`TRX_MODE_NORMAL, 1'b1, 1'b0);
    check("ls_wait", ls, 1'b0);
    sel_n = 1'b1;
    cyc(5);
    check("ls_set", ls, 1'b1);
    sel_n = 1'b0;
    wcfg(`TRX_MODE_NORMAL, 1'b1, 1'b1);
    check("bp_wait", bp, 1'b0);
    sel_n = 1'b1;
    cyc(5);
    check("bp_set", bp, 1'b1);
    chip = `CHIP_STOP;
    sel_n = 1'b0;
    wcfg(`TRX_MODE_NORMAL, 1'b0, 1'b0);
    sel_n = 1'b1;
    cyc(5);
    check("ls_stop", ls, 1'b1);
    check("bp_stop", bp, 1'b1);
    // Back in normal mode a bare select pulse must reapply the bits staged before stop
    chip = `CHIP_NORMAL;
    sel_n = 1'b0;
    cyc(4);
    sel_n = 1'b1;
    cyc(5);
    check("ls_kept", ls, 1'b1);
    check("bp_kept", bp, 1'b1);
    done("slope");
    // Fill the buffer with the drain stalled, one word every other cycle
    for (int i = 0; i < 40; i++) begin
      fin_data = 8'(i);
      fin_valid = 1'b1;
      if (fin_ready === 1'b1) q.push_back(8'(i));
      cyc(1);
      fin_valid = 1'b0;
      cyc(1);
    end
    // Buffer words plus the one held in the registered output slot
    check("fifo_count", 8'(q.size()), 8'(`FIFO_DEPTH + 1));
    // Drain and compare order
    while (q.size() > 0) begin
      for (int k = 0; k < 10 && fout_valid !== 1'b1; k++) cyc(1);
      check("fifo_data", fout_data, q.pop_front());
      fout_ready = 1'b1;
      cyc(1);
      fout_ready = 1'b0;
      cyc(2);
    end
    check("fifo_empty", fout_valid, 1'b0);
    done("fifo");
    end_of_test();
  end
endmodule
